/* File: common/pdfm_params.svh */
// Register offsets, write masks, reset values and drive codes for the pad drive and function mux
`ifndef PDFM_PARAMS_SVH
`define PDFM_PARAMS_SVH
`define PDFM_ADDR_W        3
`define PDFM_OFF_P0DRV     3'h0
`define PDFM_OFF_P1DRV_LO  3'h1
`define PDFM_OFF_P1DRV_HI  3'h2
`define PDFM_OFF_P2DRV     3'h3
`define PDFM_OFF_P3DRV_LO  3'h4
`define PDFM_OFF_P3DRV_HI  3'h5
`define PDFM_OFF_ROUTE     3'h6
`define PDFM_RESET_VAL     8'h00
`define PDFM_P0_MASK       8'hf3
`define PDFM_P3HI_MASK     8'he0
`define PDFM_ROUTE_MASK    8'h7f
`define PDFM_P1HI_MASK     8'h7f
`define PDFM_DRV_NORMAL    2'h0
`define PDFM_DRV_RES       2'h1
`define PDFM_DRV_STRONG    2'h2
`endif

/* File: common/pdfm_pkg.sv */
// Types shared by the pad drive and function mux
package pdfm_pkg;
  typedef enum logic [1:0] {
    PDFM_NORMAL = 2'b00,
    PDFM_RESIST = 2'b01,
    PDFM_STRONG = 2'b10
  } pdfm_drive_type;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pdfm_bus_req_type;

  typedef struct packed {
    logic second_uart_route;
    logic second_spi_route;
    logic first_spi_dout_alt_pin_en;
    logic [1:0] wake_event2_source_sel;
    logic dual_card_mode;
    logic sd_pin_group_sel;
  } pdfm_route_type;
endpackage

/* File: hdl/pdfm_top.sv */
// Pad drive selection and pin function routing registers for a four-port microcontroller
// What this block does
// - Pin 0.7 uses normal driver at 0, resistor drive at 1.
// - Port-0 pins 6,5,4,1,0 drive bits enable their resistor when set.
// - Pins 1.0-1.3: 00 normal, 01 resistor, upper bit set strong.
// - One-bit drive fields: 0 normal driver, 1 resistor drive.
// - Pins 2.7 and 3.2: 00 normal, 01 resistor, 10/11 strong.
// - Pin 3.5 bit set selects higher-value resistor drive.
// - Group A SD pins resistor-driven when its enable set, else they follow their own drive fields.
// - Group B SD pins resistor-driven when its enable set, else they follow their own drive fields.
// - SD resistor value: 0 high value, 1 low value.
// - Port-2 register bit 7 drives USB slew select bit 0.
// - Second UART on 3.6/3.7 at 0, on 1.6/1.7 at 1.
// - Second SPI on 0.4-0.6 at 0, on 3.0-3.2 at 1.
// - First SPI data output appears on pin 2.5 only when enabled.
// - Wake event 2 source: int2, USB D+, USB D-, IR wake.
// - Dual-card mode lets two cards share pin 3.0 as clock.
// - SD clock/cmd/data0 on 3.0-3.2 at 0, on 2.0/2.1/2.7 at 1.
// - Selected wake source feeds the event 2 pending flag.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
`include "pdfm_params.svh"
module pdfm_top (
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     resetn_in,
  // Register port
  input  wire pdfm_pkg::pdfm_bus_req_type bus_in,
  output logic [7:0]                    rdata_out,
  // Pad drive modes, one per pin of ports 0..3
  output pdfm_pkg::pdfm_drive_type      pad_drive_out [32],
  output logic                          pin3_5_high_res_out,
  output logic                          sd_resistor_value_bit_out,
  output logic                          usb_slew_sel_bit0_out,
  // Routing
  output pdfm_pkg::pdfm_route_type      route_out,
  output logic                          pin2_5_spi_dout_out,
  input  wire logic                     first_spi_dout_in,
  // Wake event 2 sources and result
  input  wire logic                     ext_int2_in,
  input  wire logic                     usb_dp_in,
  input  wire logic                     usb_dm_in,
  input  wire logic                     ir_wake_output_in,
  output logic                          wake_event2_src_out
);
  import pdfm_pkg::*;

  logic [7:0] p0_reg, p1lo_reg, p1hi_reg, p2_reg, p3lo_reg, p3hi_reg, route_reg;
  logic [7:0] rdata_next;
  logic [1:0] field [32];
  logic       wake_src_next;

  // Register writes; masked bits never store so reserved/RO bits read zero
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      p0_reg    <= `PDFM_RESET_VAL;
      p1lo_reg  <= `PDFM_RESET_VAL;
      p1hi_reg  <= `PDFM_RESET_VAL;
      p2_reg    <= `PDFM_RESET_VAL;
      p3lo_reg  <= `PDFM_RESET_VAL;
      p3hi_reg  <= `PDFM_RESET_VAL;
      route_reg <= `PDFM_RESET_VAL;
    end else if (bus_in.wr) begin
      if (bus_in.addr == `PDFM_OFF_P0DRV) begin
        p0_reg <= bus_in.wdata & `PDFM_P0_MASK;
      end else if (bus_in.addr == `PDFM_OFF_P1DRV_LO) begin
        p1lo_reg <= bus_in.wdata;
      end else if (bus_in.addr == `PDFM_OFF_P1DRV_HI) begin
        p1hi_reg <= bus_in.wdata & `PDFM_P1HI_MASK;
      end else if (bus_in.addr == `PDFM_OFF_P2DRV) begin
        p2_reg <= bus_in.wdata;
      end else if (bus_in.addr == `PDFM_OFF_P3DRV_LO) begin
        p3lo_reg <= bus_in.wdata;
      end else if (bus_in.addr == `PDFM_OFF_P3DRV_HI) begin
        p3hi_reg <= bus_in.wdata & `PDFM_P3HI_MASK;
      end else if (bus_in.addr == `PDFM_OFF_ROUTE) begin
        route_reg <= bus_in.wdata & `PDFM_ROUTE_MASK;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_next = 8'h00;
    if (bus_in.addr == `PDFM_OFF_P0DRV) begin
      rdata_next = p0_reg;
    end else if (bus_in.addr == `PDFM_OFF_P1DRV_LO) begin
      rdata_next = p1lo_reg;
    end else if (bus_in.addr == `PDFM_OFF_P1DRV_HI) begin
      rdata_next = p1hi_reg;
    end else if (bus_in.addr == `PDFM_OFF_P2DRV) begin
      rdata_next = p2_reg;
    end else if (bus_in.addr == `PDFM_OFF_P3DRV_LO) begin
      rdata_next = p3lo_reg;
    end else if (bus_in.addr == `PDFM_OFF_P3DRV_HI) begin
      rdata_next = p3hi_reg;
    end else if (bus_in.addr == `PDFM_OFF_ROUTE) begin
      rdata_next = route_reg;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (bus_in.rd) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // Raw two-bit code per pin; one-bit fields get a zero upper bit
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      field[i] = 2'b00;
    end
    field[7]  = {1'b0, p0_reg[7]};
    field[6]  = {1'b0, p0_reg[6]};
    field[5]  = {1'b0, p0_reg[5]};
    field[4]  = {1'b0, p0_reg[4]};
    field[1]  = {1'b0, p0_reg[1]};
    field[0]  = {1'b0, p0_reg[0]};
    field[8]  = p1lo_reg[1:0];
    field[9]  = p1lo_reg[3:2];
    field[10] = p1lo_reg[5:4];
    field[11] = p1lo_reg[7:6];
    field[12] = {1'b0, p1hi_reg[0]};
    field[13] = {1'b0, p1hi_reg[1]};
    field[14] = {1'b0, p1hi_reg[2]};
    field[15] = {1'b0, p1hi_reg[3]};
    for (int i = 0; i < 7; i++) begin
      field[16 + i] = {1'b0, p2_reg[i]};
    end
    field[23] = p3lo_reg[7:6];
    field[24] = {1'b0, p3lo_reg[0]};
    field[25] = {1'b0, p3lo_reg[1]};
    field[26] = p3lo_reg[3:2];
    field[27] = {1'b0, p3lo_reg[4]};
    field[28] = {1'b0, p3lo_reg[5]};
    field[29] = {1'b0, p3hi_reg[5]};
    field[30] = {1'b0, p3hi_reg[6]};
    field[31] = {1'b0, p3hi_reg[7]};
    // SD group enables override to resistor drive
    if (p1hi_reg[6]) begin
      field[16] = `PDFM_DRV_RES;
      field[17] = `PDFM_DRV_RES;
      field[23] = `PDFM_DRV_RES;
    end
    if (p1hi_reg[5]) begin
      field[24] = `PDFM_DRV_RES;
      field[25] = `PDFM_DRV_RES;
      field[26] = `PDFM_DRV_RES;
    end
  end

  // Registered decode so pads never see a decode glitch
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_pad
      always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pad_drive_out[g] <= PDFM_NORMAL;
        end else if (field[g][1]) begin
          pad_drive_out[g] <= PDFM_STRONG;
        end else if (field[g][0]) begin
          pad_drive_out[g] <= PDFM_RESIST;
        end else begin
          pad_drive_out[g] <= PDFM_NORMAL;
        end
      end
    end
  endgenerate

  // Misc pad controls and routing, registered one edge after the write lands
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin3_5_high_res_out       <= 1'b0;
      sd_resistor_value_bit_out <= 1'b0;
      usb_slew_sel_bit0_out     <= 1'b0;
      route_out                 <= '0;
    end else begin
      pin3_5_high_res_out       <= p3hi_reg[5];
      sd_resistor_value_bit_out <= p1hi_reg[4];
      usb_slew_sel_bit0_out     <= p2_reg[7];
      route_out                 <= route_reg[6:0];
    end
  end

  // Alternate data path and wake source are live signals, so muxed combinationally
  assign pin2_5_spi_dout_out = route_out.first_spi_dout_alt_pin_en & first_spi_dout_in;

  always_comb begin
    case (route_out.wake_event2_source_sel)
      2'b00:   wake_src_next = ext_int2_in;
      2'b01:   wake_src_next = usb_dp_in;
      2'b10:   wake_src_next = usb_dm_in;
      default: wake_src_next = ir_wake_output_in;
    endcase
  end
  assign wake_event2_src_out = wake_src_next;

  // Checks
  // A routing write as seen on the register port
  sequence route_write_seen;
    bus_in.wr && bus_in.addr == `PDFM_OFF_ROUTE;
  endsequence

  // Pad decode follows the stored field one edge later
  chk_p07_res: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p0_reg[7] |=> pad_drive_out[7] == PDFM_RESIST) else $error("pin0.7 not resistor");
  chk_p00_res: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p0_reg[0] |=> pad_drive_out[0] == PDFM_RESIST) else $error("pin0.0 resistor not enabled");
  chk_p14_res: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p1hi_reg[0] |=> pad_drive_out[12] == PDFM_RESIST) else $error("pin1.4 not resistor");
  chk_strong_p32: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p3lo_reg[3] && !p1hi_reg[5] |=> pad_drive_out[26] == PDFM_STRONG) else $error("pin3.2 not strong");
  chk_p35_high: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p3hi_reg[5] |=> pin3_5_high_res_out && pad_drive_out[29] == PDFM_RESIST)
    else $error("pin3.5 not high-value resistor");

  // Level controls are plain registered copies of their bits
  chk_sd_value: assert property (@(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> sd_resistor_value_bit_out == $past(p1hi_reg[4])) else $error("sd resistor value wrong");
  chk_usb_slew: assert property (@(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> usb_slew_sel_bit0_out == $past(p2_reg[7])) else $error("usb slew bit wrong");
  chk_route_copy: assert property (@(posedge clk_in) disable iff (!resetn_in)
    1'b1 |=> route_out == $past(route_reg[6:0])) else $error("routing copy wrong");

  // Alternate data path and wake source selection
  chk_spi_alt_on: assert property (@(posedge clk_in) disable iff (!resetn_in)
    route_out.first_spi_dout_alt_pin_en |-> pin2_5_spi_dout_out == first_spi_dout_in)
    else $error("spi data missing on pin2.5");
  chk_wake_int2: assert property (@(posedge clk_in) disable iff (!resetn_in)
    route_out.wake_event2_source_sel == 2'b00 |-> wake_event2_src_out == ext_int2_in)
    else $error("wake source not int2");
  chk_wake_dp: assert property (@(posedge clk_in) disable iff (!resetn_in)
    route_out.wake_event2_source_sel == 2'b01 |-> wake_event2_src_out == usb_dp_in)
    else $error("wake source not usb dp");
  chk_wake_dm: assert property (@(posedge clk_in) disable iff (!resetn_in)
    route_out.wake_event2_source_sel == 2'b10 |-> wake_event2_src_out == usb_dm_in)
    else $error("wake source not usb dm");

  // Read data stands for one cycle only, zero otherwise
  chk_rdata_idle: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !bus_in.rd |=> rdata_out == 8'h00) else $error("read data not cleared");

  chk_p0_mask: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p0_reg[3:2] == 2'b00) else $error("reserved port0 bits stored");
  chk_p3_ro: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p3hi_reg[4:0] == 5'h00) else $error("read-only bits stored");
  chk_write_reach: assert property (@(posedge clk_in) disable iff (!resetn_in)
    route_write_seen |-> ##2 route_out == $past(bus_in.wdata[6:0], 2))
    else $error("routing not updated two edges after write");
  chk_strong_p10: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p1lo_reg[1] |=> pad_drive_out[8] == PDFM_STRONG) else $error("pin1.0 not strong");
  chk_res_p27: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p3lo_reg[7:6] == 2'b01 |=> pad_drive_out[23] == PDFM_RESIST) else $error("pin2.7 not resistor");
  chk_sd_group_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p1hi_reg[6] |=> pad_drive_out[17] == PDFM_RESIST) else $error("group A not resistor");
  chk_sd_group_b: assert property (@(posedge clk_in) disable iff (!resetn_in)
    p1hi_reg[5] |=> pad_drive_out[26] == PDFM_RESIST) else $error("group B not resistor");
  chk_spi_alt_off: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !route_out.first_spi_dout_alt_pin_en |-> !pin2_5_spi_dout_out) else $error("spi on pin2.5");
  chk_wake_sel: assert property (@(posedge clk_in) disable iff (!resetn_in)
    route_out.wake_event2_source_sel == 2'b11 |-> wake_event2_src_out == ir_wake_output_in)
    else $error("wake source select wrong");
  chk_read_data: assert property (@(posedge clk_in) disable iff (!resetn_in)
    bus_in.rd && bus_in.addr == `PDFM_OFF_P2DRV |=> rdata_out == $past(p2_reg))
    else $error("read data mismatch");
endmodule

/* File: testbench/pdfm_top_tb.sv */
// Self-checking bench for the pad drive and function mux registers
`timescale 1ns/10ps
module pdfm_top_tb;
  import pdfm_pkg::*;
  logic             clk_in = 1'b0;
  logic             resetn_in = 1'b0;
  pdfm_bus_req_type bus_in = '0;
  logic [7:0]       rdata_out;
  pdfm_drive_type   pad_drive_out [32];
  logic             pin3_5_high_res_out;
  logic             sd_resistor_value_bit_out;
  logic             usb_slew_sel_bit0_out;
  pdfm_route_type   route_out;
  logic             pin2_5_spi_dout_out;
  logic             wake_event2_src_out;
  logic [4:0]       src_in = 5'h00;
  logic [7:0]       regs [8];
  logic [7:0]       v;
  integer           errors = 0;
  integer           checks = 0;
  integer           cycles = 0;
  integer           seed = 32'h7cbb9326;
  integer           i;
  integer           k;
  integer           n;

  // Free-running 100 MHz clock
  always #5 clk_in = ~clk_in;

  // Cut a hung run short; the whole sequence needs well under a thousand cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  // Sources: src_in = {first spi dout, int2, usb dp, usb dm, ir wake}
  pdfm_top dut (
    .clk_in                    (clk_in),
    .resetn_in                 (resetn_in),
    .bus_in                    (bus_in),
    .rdata_out                 (rdata_out),
    .pad_drive_out             (pad_drive_out),
    .pin3_5_high_res_out       (pin3_5_high_res_out),
    .sd_resistor_value_bit_out (sd_resistor_value_bit_out),
    .usb_slew_sel_bit0_out     (usb_slew_sel_bit0_out),
    .route_out                 (route_out),
    .pin2_5_spi_dout_out       (pin2_5_spi_dout_out),
    .first_spi_dout_in         (src_in[4]),
    .ext_int2_in               (src_in[3]),
    .usb_dp_in                 (src_in[2]),
    .usb_dm_in                 (src_in[1]),
    .ir_wake_output_in         (src_in[0]),
    .wake_event2_src_out       (wake_event2_src_out)
  );

  task automatic stop_test;
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      errors = errors + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Writable bits per index; reserved bits and the unmapped index keep zero
  function automatic logic [7:0] mask(input logic [2:0] a);
    case (a)
      3'h0: mask = 8'hf3;
      3'h2: mask = 8'h7f;
      3'h5: mask = 8'he0;
      3'h6: mask = 8'h7f;
      3'h7: mask = 8'h00;
      default: mask = 8'hff;
    endcase
  endfunction

  // Expected drive mode of pin p (port*8+bit) from the shadow registers
  function automatic pdfm_drive_type exp_pad(input integer p);
    logic [1:0] f;
    integer     b3 [8];
    b3 = '{0, 1, 2, 4, 5, 5, 6, 7};
    if (p < 8) f = {1'b0, regs[0][p]};
    else if (p < 12) f = regs[1][2*(p-8) +: 2];
    else if (p < 16) f = {1'b0, regs[2][p-12]};
    else if (p == 23) f = regs[4][7:6];
    else if (p < 24) f = {1'b0, regs[3][p-16]};
    else if (p == 26) f = regs[4][3:2];
    else f = {1'b0, (p < 29) ? regs[4][b3[p-24]] : regs[5][b3[p-24]]};
    // Group enables force resistor drive over the per-pin field
    if ((regs[2][6] && (p == 16 || p == 17 || p == 23)) || (regs[2][5] && p >= 24 && p <= 26)) f = 2'b01;
    exp_pad = f[1] ? PDFM_STRONG : (f[0] ? PDFM_RESIST : PDFM_NORMAL);
  endfunction

  task automatic check_all;
    for (n = 0; n < 32; n++) check("pad", 8'(pad_drive_out[n]), 8'(exp_pad(n)));
    check("high_res", 8'(pin3_5_high_res_out), 8'(regs[5][5]));
    check("sd_res", 8'(sd_resistor_value_bit_out), 8'(regs[2][4]));
    check("usb_slew", 8'(usb_slew_sel_bit0_out), 8'(regs[3][7]));
    check("route", 8'(route_out), regs[6]);
    check("spi_dout", 8'(pin2_5_spi_dout_out), 8'(regs[6][4] & src_in[4]));
    check("wake", 8'(wake_event2_src_out), 8'(src_in[2'd3 - regs[6][3:2]]));
  endtask

  // Bus tasks start right after an edge and leave the strobes for the next call
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus_in <= {a, d, 2'b10};
    @(posedge clk_in);
    regs[a] = d & mask(a);
  endtask

  task automatic rd(input logic [2:0] a);
    bus_in <= {a, 8'h00, 2'b01};
    @(posedge clk_in);
    #1 check("rdata", rdata_out, regs[a]);
  endtask

  task automatic idle;
    bus_in <= '0;
    @(posedge clk_in);
  endtask

  // Main sequence: reset values, directed corners, random fills, reset in mid-run
  initial begin
    for (i = 0; i < 8; i++) regs[i] = 8'h00;
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    #1 check_all;
    for (i = 0; i < 8; i++) rd(3'(i));
    for (k = 0; k < 40; k++) begin
      for (i = 0; i < 8; i++) begin
        v = (k == 0) ? 8'hff : (k == 1) ? 8'haa : (k == 2) ? 8'h55 : 8'($random(seed));
        wr(3'(i), v);
        rd(3'(i));
      end
      src_in <= 5'($random(seed));
      idle;
      idle;
      #1 check_all;
      check("rdata_idle", rdata_out, 8'h00);
    end
    resetn_in <= 1'b0;
    for (i = 0; i < 8; i++) regs[i] = 8'h00;
    @(posedge clk_in);
    #1 check_all;
    resetn_in <= 1'b1;
    idle;
    for (i = 0; i < 8; i++) rd(3'(i));
    stop_test();
  end
endmodule
